// *** dv/sltic_link_ctrl_assertions.sv ***
`timescale 1ns/1ps
module sltic_link_ctrl_assertions #(
  parameter WORD_W = 16
) (
  // Clock and reset
  input logic              mclk,
  input logic              reset_n,
  // Link state
  input logic              lmfcBoundary_ff,
  input logic [3:0]        linkState_ff,
  input logic              ilasStart_ff,
  // Test data
  input logic              testStrobe_ff,
  input logic [WORD_W-1:0] testData_ff,
  input logic              injSample_ff,
  input logic              injEncoder_ff,
  input logic              injScrambler_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_ilas_on_mf;
    ilasStart_ff |-> lmfcBoundary_ff && linkState_ff == 4'h4;
  endproperty
  a_ilas_on_mf: assert property (p_ilas_on_mf)
    else $error("alignment start off a boundary");
  property p_ilas_from_wait;
    ilasStart_ff |-> $past(linkState_ff) == 4'h2;
  endproperty
  a_ilas_from_wait: assert property (p_ilas_from_wait)
    else $error("alignment start not from wait");
  property p_enter_ilas; $rose(linkState_ff[2]) |-> ilasStart_ff; endproperty
  a_enter_ilas: assert property (p_enter_ilas)
    else $error("alignment state without start pulse");
  property p_data_from_ilas;
    $rose(linkState_ff[3]) |-> $past(linkState_ff[2]) && lmfcBoundary_ff;
  endproperty
  a_data_from_ilas: assert property (p_data_from_ilas)
    else $error("data state not after alignment");
  property p_cgs_exit;
    $fell(linkState_ff[0]) |-> linkState_ff == 4'h2;
  endproperty
  a_cgs_exit: assert property (p_cgs_exit)
    else $error("sync state left to wrong state");
  property p_onehot; $onehot(linkState_ff); endproperty
  a_onehot: assert property (p_onehot)
    else $error("link state not one-hot");
  property p_inj_one;
    $onehot0({injSample_ff, injEncoder_ff, injScrambler_ff});
  endproperty
  a_inj_one: assert property (p_inj_one)
    else $error("two injection points at once");
  // Return to zero is allowed without a strobe on pattern change
  property p_data_moves;
    $changed(testData_ff) && testData_ff != '0 |-> testStrobe_ff;
  endproperty
  a_data_moves: assert property (p_data_moves)
    else $error("test word changed without strobe");
endmodule

bind sltic_link_ctrl sltic_link_ctrl_assertions #(.WORD_W(WORD_W)) i_chk (
  .mclk(mclk), .reset_n(reset_n), .lmfcBoundary_ff(lmfcBoundary_ff),
  .linkState_ff(linkState_ff), .ilasStart_ff(ilasStart_ff),
  .testStrobe_ff(testStrobe_ff), .testData_ff(testData_ff),
  .injSample_ff(injSample_ff), .injEncoder_ff(injEncoder_ff),
  .injScrambler_ff(injScrambler_ff));

// *** dv/sltic_link_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "sltic_regs.vh"
module sltic_link_ctrl_tb_top;
  localparam FD = 2;
  localparam logic [7:0] CK [4] = '{8'hb5, 8'h18, 8'h00, 8'hb5};
  localparam logic [2:0] INJ [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
  localparam int PA [5] = '{31, 23, 15, 9, 7};
  localparam int PB [5] = '{28, 18, 14, 5, 6};
  logic        mclk, reset_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic        syncReq_n, system_reference_input, mfPulse, ilasGo, tStrobe, injS, injE;
  logic        injC;
  logic [15:0] awaddr, araddr, tData;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr;
  logic [3:0]  state;
  logic [7:0]  csum;
  int          fail_count = 0;
  int          checked = 0;

  sltic_link_ctrl #(.FRAME_DIV(FD), .LMFC_FRAMES(4)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .syncRequestIn_n(syncReq_n), .systemReferenceIn(system_reference_input),
    .lmfcBoundary_ff(mfPulse), .linkState_ff(state), .ilasStart_ff(ilasGo),
    .checksum_ff(csum), .testStrobe_ff(tStrobe), .testData_ff(tData),
    .injSample_ff(injS), .injEncoder_ff(injE), .injScrambler_ff(injC));
  sltic_rx_model i_rx (.mclk(mclk), .lmfcBoundary(mfPulse),
    .syncRequestIn_n(syncReq_n), .systemReferenceIn(system_reference_input));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    rr = rresp;
  endtask

  // First two strobes skipped: the word restarts on a code change
  task automatic grab(input int c);
    logic [79:0] s;
    int e;
    e = 0;
    s = '0;
    wr(ba(`SLTIC_IDX_CHK_TEST), ((c % 4) << 4) | c, 2'h0);
    for (int k = 0; k < 7 && c > 0; k++) begin
      do @(posedge mclk); while (!tStrobe);
      s = {s[63:0], tData};
    end
    if (c == 1)
      chk(s[31:0], s[15:0] == 16'haaaa ? 32'h5555_aaaa : 32'haaaa_5555);
    if (c == 2)
      chk(s[31:0], s[15:0] == 16'hffff ? 32'h0000_ffff : 32'hffff_0000);
    if (c == 8)
      chk(s[15:0] - s[31:16], 32'h0000_0001);
    if (c == 14)
      chk(s[15:0], 16'h1234);
    if (c > 2 && c < 8) begin
      for (int j = 0; j < 80 - PA[c-3]; j++)
        e += (s[j] !== (s[j+PA[c-3]] ^ s[j+PB[c-3]]));
      chk(e, 0);
      chk(|s, 1);
    end
    // Injection flags settle one cycle after the register write
    @(posedge mclk);
    chk({injS, injE, injC}, c ? INJ[c % 4] : 3'h0);
  endtask

  task automatic ilas(input int n);
    int cnt;
    cnt = 0;
    wr(ba(`SLTIC_IDX_ALIGN_DLY), n << 4, 2'h0);
    rd(ba(`SLTIC_IDX_ALIGN_DLY));
    chk(rv, n << 4);
    i_rx.requestSync();
    repeat (10) @(posedge mclk);
    chk(state, 4'h1);
    i_rx.releaseSync();
    do begin
      @(posedge mclk);
      cnt += mfPulse;
    end while (!ilasGo);
    chk(cnt, n + 1);
    for (int k = 0; k < 4; k++)
      do @(posedge mclk); while (!mfPulse);
    chk(state, 4'h8);
  endtask

  task automatic sref(input int o, output int t);
    wr(ba(`SLTIC_IDX_LMFC_OFS), o, 2'h0);
    do @(posedge mclk); while (!mfPulse);
    i_rx.pulseSysref();
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (!mfPulse);
  endtask

  initial begin
    #(20000 * 8);
    fail_count++;
    test_done();
  end

  initial begin
    int t0, t2;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    reset_n = 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rd(ba(`SLTIC_IDX_CHK_TEST));
    chk(rv, 0);
    rd(ba(`SLTIC_IDX_ALIGN_DLY));
    chk(rv, 0);
    wr(ba(`SLTIC_IDX_CHK_TEST) | 16'h0001, 8'hff, `SLTIC_RESP_SLVERR);
    wr(16'h0004, 8'hff, `SLTIC_RESP_SLVERR);
    rd(16'h0004);
    chk(rr, `SLTIC_RESP_SLVERR);
    rd(ba(`SLTIC_IDX_CHK_TEST));
    chk(rv, 0);
    // Octets 0x10 0x21 0x00 0x83 0x01: table sum b5, field sum 18
    wr(ba(`SLTIC_IDX_CFG0), 32'h8300_2110, 2'h0);
    wr(ba(`SLTIC_IDX_CFG1), 32'h0000_0001, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wr(ba(`SLTIC_IDX_CHK_TEST), m << 6, 2'h0);
      rd(ba(`SLTIC_IDX_STATUS));
      chk({csum, rv[23:16]}, {2{CK[m]}});
    end
    wr(ba(`SLTIC_IDX_USER_PAT), 32'h0000_1234, 2'h0);
    grab(14);
    for (int c = 8; c >= 0; c--) grab(c);
    ilas(0);
    ilas(3);
    ilas(15);
    wr(ba(`SLTIC_IDX_SYNC_CTRL), 8'h80, 2'h0);
    repeat (4) @(posedge mclk);
    chk(state, 4'h1);
    i_rx.requestSync();
    wr(ba(`SLTIC_IDX_SYNC_CTRL), 8'hc0, 2'h0);
    repeat (200) @(posedge mclk);
    chk(state, 4'h8);
    wr(ba(`SLTIC_IDX_SYNC_CTRL), 8'h00, 2'h0);
    repeat (4) @(posedge mclk);
    chk(state, 4'h1);
    sref(0, t0);
    sref(2, t2);
    chk(t0 - t2, 2 * FD);
    test_done();
  end
endmodule

// *** dv/sltic_rx_model.sv ***
`timescale 1ns/1ps
module sltic_rx_model (
  // Clock and multiframe timing
  input  logic mclk,
  input  logic lmfcBoundary,
  // Link pins toward the transmitter
  output logic syncRequestIn_n,
  output logic systemReferenceIn
);
  initial begin
    syncRequestIn_n = 1'b0;
    systemReferenceIn = 1'b0;
  end
  task automatic requestSync();
    @(posedge mclk);
    syncRequestIn_n <= 1'b0;
  endtask
  // Release right after a boundary so the next is a full multiframe away
  task automatic releaseSync();
    do @(posedge mclk); while (!lmfcBoundary);
    syncRequestIn_n <= 1'b1;
  endtask
  task automatic pulseSysref();
    @(posedge mclk);
    systemReferenceIn <= 1'b1;
    @(posedge mclk);
    systemReferenceIn <= 1'b0;
  endtask
endmodule

// *** hw/sltic_link_ctrl.v ***
// Notes on behaviour
// R1 - Checksum mode 00: sum all table octets
// R2 - Checksum mode 01: sum LSB-aligned config fields
// R3 - Checksum mode 10: checksum sent as zero
// R4 - Injection 1: 10-bit symbols after encoder
// R5 - Injection 2: octets at scrambler input
// R6 - Pattern 0 normal, 1 checkerboard, 2 toggle
// R7 - Pattern 3: PN x^31+x^28+1
// R8 - Pattern 4: PN x^23+x^18+1
// R9 - Pattern 5: PN x^15+x^14+1
// R10 - Pattern 6: PN x^9+x^5+1
// R11 - Pattern 7: PN x^7+x^6+1
// R12 - ILAS on (n+1)th boundary after sync release
// R13 - Sync request drives CGS unless forced
// R14 - Reference input loads multiframe phase offset
// R15 - Injection 0 at samples; reserved codes normal (reserved pattern codes 9-13 still set an injection flag, with a zero word)
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "sltic_regs.vh"

module sltic_link_ctrl #(
  parameter ADDR_W      = 16,
  parameter WORD_W      = 16,
  parameter FRAME_DIV   = 4,
  parameter LMFC_FRAMES = 32,
  parameter ILAS_MF     = 4
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              reset_n,
  // AXI4-Lite write
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Link pins
  input  wire              syncRequestIn_n,
  input  wire              systemReferenceIn,
  // Link timing and state
  output reg               lmfcBoundary_ff,
  output reg  [3:0]        linkState_ff,
  output reg               ilasStart_ff,
  output reg  [7:0]        checksum_ff,
  // Test injection
  output reg               testStrobe_ff,
  output wire [WORD_W-1:0] testData_ff,
  output reg               injSample_ff,
  output reg               injEncoder_ff,
  output reg               injScrambler_ff
);

  localparam ST_CGS  = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_ILAS = 4'b0100;
  localparam ST_DATA = 4'b1000;

  localparam [7:0] DIV_LAST  = FRAME_DIV[7:0] - 8'h01;
  localparam [4:0] LMFC_LAST = LMFC_FRAMES[4:0] - 5'h01;
  localparam [3:0] ILAS_LAST = ILAS_MF[3:0] - 4'h1;

  // Registers
  reg  [7:0]  syncCtrl_ff;
  reg  [7:0]  chkTest_ff;
  reg  [7:0]  alignDly_ff;
  reg  [7:0]  lmfcOfs_ff;
  reg  [31:0] cfg0_ff;
  reg  [31:0] cfg1_ff;
  reg  [31:0] cfg2_ff;
  reg  [31:0] cfg3_ff;
  reg  [31:0] userPat_ff;
  // Bus state
  reg              awHeld_ff;
  reg              wHeld_ff;
  reg [ADDR_W-1:0] awAddr_ff;
  reg [31:0]       wData_ff;
  reg [3:0]        wStrb_ff;
  // Link timing
  reg  [7:0]  divCnt_ff;
  reg         frameEn_ff;
  reg  [4:0]  lmfcCnt_ff;
  reg         sysrefLast_ff;
  reg  [3:0]  mfCnt_ff;
  reg  [3:0]  nxt_linkState;
  reg  [3:0]  nxt_mfCnt;
  reg         nxt_ilasStart;

  wire [1:0]  chkMode   = chkTest_ff[`SLTIC_CHK_MSB:`SLTIC_CHK_LSB];
  wire [1:0]  injPoint  = chkTest_ff[`SLTIC_INJ_MSB:`SLTIC_INJ_LSB];
  wire [3:0]  patSel    = chkTest_ff[`SLTIC_PAT_MSB:`SLTIC_PAT_LSB];
  wire [3:0]  ilasDelay = alignDly_ff[`SLTIC_DLY_MSB:`SLTIC_DLY_LSB];
  wire [1:0]  syncMode  = syncCtrl_ff[`SLTIC_SYNC_MSB:`SLTIC_SYNC_LSB];
  wire [103:0] cfgTable = {cfg3_ff[7:0], cfg2_ff, cfg1_ff, cfg0_ff};
  wire        sysrefRise = systemReferenceIn & ~sysrefLast_ff;
  wire        boundary  = frameEn_ff && (lmfcCnt_ff == LMFC_LAST);
  wire        syncReq;

  // Register select: 4'hf marks an unmapped address
  function [3:0] regSel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[ADDR_W-1:14] != 0)
        regSel = 4'hf;
      else begin
        case (addr[13:2])
          `SLTIC_IDX_SYNC_CTRL: regSel = 4'h0;
          `SLTIC_IDX_CHK_TEST:  regSel = 4'h1;
          `SLTIC_IDX_ALIGN_DLY: regSel = 4'h2;
          `SLTIC_IDX_LMFC_OFS:  regSel = 4'h3;
          `SLTIC_IDX_CFG0:      regSel = 4'h4;
          `SLTIC_IDX_CFG1:      regSel = 4'h5;
          `SLTIC_IDX_CFG2:      regSel = 4'h6;
          `SLTIC_IDX_CFG3:      regSel = 4'h7;
          `SLTIC_IDX_USER_PAT:  regSel = 4'h8;
          `SLTIC_IDX_STATUS:    regSel = 4'h9;
          default:              regSel = 4'hf;
        endcase
      end
    end
  endfunction

  function [31:0] applyStrb;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      applyStrb = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          applyStrb[8*i+:8] = data[8*i+:8];
    end
  endfunction

  // Octets are the fixed table image; fields are summed LSB aligned
  function [7:0] lineChecksum;
    input [1:0]   mode;
    input [103:0] t;
    reg   [11:0]  s;
    integer       i;
    begin
      s = 12'h000;
      if (mode == `SLTIC_CHK_FIELDS) begin // see R2
        s = s + {4'h0, t[7:0]};
        s = s + {8'h00, t[11:8]} + {8'h00, t[15:12]};
        s = s + {7'h00, t[20:16]} + {11'h000, t[21]} + {11'h000, t[22]};
        s = s + {7'h00, t[28:24]} + {11'h000, t[31]};
        s = s + {4'h0, t[39:32]} + {7'h00, t[44:40]};
        s = s + {4'h0, t[55:48]};
        s = s + {7'h00, t[60:56]} + {10'h000, t[63:62]};
        s = s + {7'h00, t[68:64]} + {9'h000, t[71:69]};
        s = s + {7'h00, t[76:72]} + {9'h000, t[79:77]};
        s = s + {7'h00, t[84:80]} + {11'h000, t[87]};
        s = s + {4'h0, t[95:88]} + {4'h0, t[103:96]};
      end else if (mode != `SLTIC_CHK_ZERO) begin // see R1 see R15
        for (i = 0; i < 13; i = i + 1)
          s = s + {4'h0, t[8*i+:8]};
      end
      lineChecksum = s[7:0]; // see R3
    end
  endfunction

  // Register read mux; narrow registers sit in the low bits
  function [31:0] readMux;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    readMux = {24'h00_0000, syncCtrl_ff[7:6], 6'h00};
        4'h1:    readMux = {24'h00_0000, chkTest_ff};
        4'h2:    readMux = {24'h00_0000, alignDly_ff[7:4], 4'h0};
        4'h3:    readMux = {24'h00_0000, 3'h0, lmfcOfs_ff[4:0]};
        4'h4:    readMux = cfg0_ff;
        4'h5:    readMux = cfg1_ff;
        4'h6:    readMux = cfg2_ff;
        4'h7:    readMux = {24'h00_0000, cfg3_ff[7:0]};
        4'h8:    readMux = {16'h0000, userPat_ff[15:0]};
        4'h9:    readMux = {8'h00, checksum_ff, 3'h0, lmfcCnt_ff,
                            4'h0, linkState_ff};
        default: readMux = 32'h0000_0000;
      endcase
    end
  endfunction

  // AXI4-Lite slave: address and data taken in either order
  wire [3:0] wSel   = regSel(awAddr_ff);
  wire       doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  wire       awTake  = s_axi_awvalid & s_axi_awready;
  wire       wTake   = s_axi_wvalid & s_axi_wready;
  wire       arTake  = s_axi_arvalid & s_axi_arready;
  wire       bDone   = s_axi_bvalid & s_axi_bready;
  wire       rDone   = s_axi_rvalid & s_axi_rready;
  wire       nxt_awHeld = (awHeld_ff & ~doWrite) | awTake;
  wire       nxt_wHeld  = (wHeld_ff & ~doWrite) | wTake;
  wire       nxt_bvalid = (s_axi_bvalid & ~bDone) | doWrite;
  wire       nxt_rvalid = (s_axi_rvalid & ~rDone) | arTake;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SLTIC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SLTIC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      awHeld_ff     <= 1'b0;
      wHeld_ff      <= 1'b0;
      awAddr_ff     <= {ADDR_W{1'b0}};
      wData_ff      <= 32'h0000_0000;
      wStrb_ff      <= 4'h0;
      syncCtrl_ff   <= `SLTIC_RST_BYTE;
      chkTest_ff    <= `SLTIC_RST_BYTE;
      alignDly_ff   <= `SLTIC_RST_BYTE;
      lmfcOfs_ff    <= `SLTIC_RST_BYTE;
      cfg0_ff       <= `SLTIC_RST_WORD;
      cfg1_ff       <= `SLTIC_RST_WORD;
      cfg2_ff       <= `SLTIC_RST_WORD;
      cfg3_ff       <= `SLTIC_RST_WORD;
      userPat_ff    <= `SLTIC_RST_WORD;
    end else begin
      awHeld_ff     <= nxt_awHeld;
      wHeld_ff      <= nxt_wHeld;
      s_axi_bvalid  <= nxt_bvalid;
      s_axi_rvalid  <= nxt_rvalid;
      // One write and one read in flight at a time
      s_axi_awready <= ~nxt_awHeld & ~nxt_bvalid;
      s_axi_wready  <= ~nxt_wHeld & ~nxt_bvalid;
      s_axi_arready <= ~nxt_rvalid;
      if (awTake)
        awAddr_ff <= s_axi_awaddr;
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (arTake) begin
        s_axi_rdata <= readMux(regSel(s_axi_araddr));
        s_axi_rresp <= (regSel(s_axi_araddr) == 4'hf) ?
                       `SLTIC_RESP_SLVERR : `SLTIC_RESP_OKAY;
      end
      if (doWrite) begin
        s_axi_bresp <= (wSel == 4'hf) ?
                       `SLTIC_RESP_SLVERR : `SLTIC_RESP_OKAY;
        if (wStrb_ff[0]) begin
          case (wSel)
            4'h0: syncCtrl_ff <= {wData_ff[7:6], 6'h00};
            4'h1: chkTest_ff  <= wData_ff[7:0];
            4'h2: alignDly_ff <= {wData_ff[7:4], 4'h0};
            4'h3: lmfcOfs_ff  <= {3'h0, wData_ff[4:0]};
            4'h7: cfg3_ff     <= {24'h00_0000, wData_ff[7:0]};
            default: ;
          endcase
        end
        case (wSel)
          4'h4: cfg0_ff <= applyStrb(cfg0_ff, wData_ff, wStrb_ff);
          4'h5: cfg1_ff <= applyStrb(cfg1_ff, wData_ff, wStrb_ff);
          4'h6: cfg2_ff <= applyStrb(cfg2_ff, wData_ff, wStrb_ff);
          4'h8: userPat_ff <= applyStrb(userPat_ff, wData_ff,
                                        wStrb_ff) & 32'h0000_ffff;
          default: ;
        endcase
      end
    end
  end

  // Frame enable and multiframe phase
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_ff       <= 8'h00;
      frameEn_ff      <= 1'b0;
      lmfcCnt_ff      <= 5'h00;
      sysrefLast_ff   <= 1'b0;
      lmfcBoundary_ff <= 1'b0;
    end else begin
      sysrefLast_ff   <= systemReferenceIn;
      lmfcBoundary_ff <= boundary;
      if (sysrefRise) begin
        // Restarting the divider keeps the phase deterministic
        divCnt_ff  <= 8'h00;
        frameEn_ff <= 1'b0;
        lmfcCnt_ff <= lmfcOfs_ff[`SLTIC_OFS_MSB:0]; // see R14
      end else begin
        frameEn_ff <= (divCnt_ff == DIV_LAST);
        divCnt_ff  <= (divCnt_ff == DIV_LAST) ? 8'h00 :
                      divCnt_ff + 8'h01;
        if (frameEn_ff)
          lmfcCnt_ff <= (lmfcCnt_ff == LMFC_LAST) ? 5'h00 :
                        lmfcCnt_ff + 5'h01;
      end
    end
  end

  // Forced modes override the pin; code 01 behaves as normal
  assign syncReq = (syncMode == `SLTIC_SYNC_FORCE_CGS) ? 1'b1 :
                   (syncMode == `SLTIC_SYNC_FORCE_DATA) ? 1'b0 :
                   ~syncRequestIn_n; // see R13

  always @* begin
    nxt_linkState = linkState_ff;
    nxt_mfCnt     = mfCnt_ff;
    nxt_ilasStart = 1'b0;
    case (linkState_ff)
      ST_CGS: begin
        if (!syncReq) begin
          nxt_linkState = ST_WAIT;
          nxt_mfCnt     = 4'h0;
        end
      end
      ST_WAIT: begin
        if (syncReq)
          nxt_linkState = ST_CGS;
        else if (boundary) begin
          if (mfCnt_ff == ilasDelay) begin // see R12
            nxt_linkState = ST_ILAS;
            nxt_ilasStart = 1'b1;
            nxt_mfCnt     = 4'h0;
          end else
            nxt_mfCnt = mfCnt_ff + 4'h1;
        end
      end
      ST_ILAS: begin
        if (syncReq)
          nxt_linkState = ST_CGS;
        else if (boundary) begin
          if (mfCnt_ff == ILAS_LAST)
            nxt_linkState = ST_DATA;
          else
            nxt_mfCnt = mfCnt_ff + 4'h1;
        end
      end
      ST_DATA: begin
        if (syncReq)
          nxt_linkState = ST_CGS;
      end
      default: nxt_linkState = ST_CGS;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      linkState_ff    <= ST_CGS;
      mfCnt_ff        <= 4'h0;
      ilasStart_ff    <= 1'b0;
      checksum_ff     <= 8'h00;
      testStrobe_ff   <= 1'b0;
      injSample_ff    <= 1'b0;
      injEncoder_ff   <= 1'b0;
      injScrambler_ff <= 1'b0;
    end else begin
      linkState_ff    <= nxt_linkState;
      mfCnt_ff        <= nxt_mfCnt;
      ilasStart_ff    <= nxt_ilasStart;
      checksum_ff     <= lineChecksum(chkMode, cfgTable);
      testStrobe_ff   <= frameEn_ff;
      // Reserved injection code falls back to the sample input
      injSample_ff    <= (patSel != `SLTIC_PAT_NORMAL) &&
                         (injPoint != `SLTIC_INJ_ENCODER) &&
                         (injPoint != `SLTIC_INJ_SCRAMBLER); // see R15
      injEncoder_ff   <= (patSel != `SLTIC_PAT_NORMAL) &&
                         (injPoint == `SLTIC_INJ_ENCODER); // see R4
      injScrambler_ff <= (patSel != `SLTIC_PAT_NORMAL) &&
                         (injPoint == `SLTIC_INJ_SCRAMBLER); // see R5
    end
  end

  sltic_pattern_gen #(
    .WORD_W (WORD_W)
  ) u_pattern (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .stepEn     (frameEn_ff),
    .patSel     (patSel),
    .userWord   (userPat_ff[WORD_W-1:0]),
    .patWord_ff (testData_ff)
  );

endmodule

// *** hw/sltic_pattern_gen.v ***
`timescale 1ns/1ps
`include "sltic_regs.vh"

module sltic_pattern_gen #(
  parameter WORD_W = 16
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              reset_n,
  // Control
  input  wire              stepEn,
  input  wire [3:0]        patSel,
  input  wire [WORD_W-1:0] userWord,
  // Pattern word
  output reg  [WORD_W-1:0] patWord_ff
);

  reg  [30:0]       lfsr_ff;
  reg  [3:0]        lastSel_ff;
  reg               userSent_ff;
  reg  [WORD_W-1:0] nxt_patWord;
  reg  [30:0]       nxt_lfsr;
  reg               nxt_userSent;
  wire [30+WORD_W:0] pnStep;

  // Advances the chosen PN register by one word; returns {state, word}
  function [30+WORD_W:0] pnAdvance;
    input [30:0] state;
    input [3:0]  sel;
    reg   [30:0] s;
    reg   [WORD_W-1:0] w;
    reg   [30:0] mask;
    reg          fb;
    integer      tapA;
    integer      tapB;
    integer      i;
    begin
      s = state;
      w = {WORD_W{1'b0}};
      case (sel)
        `SLTIC_PAT_PN31: begin tapA = 31; tapB = 28; end // see R7
        `SLTIC_PAT_PN23: begin tapA = 23; tapB = 18; end // see R8
        `SLTIC_PAT_PN15: begin tapA = 15; tapB = 14; end // see R9
        `SLTIC_PAT_PN9:  begin tapA = 9;  tapB = 5;  end // see R10
        default:         begin tapA = 7;  tapB = 6;  end // see R11
      endcase
      mask = 31'h7fff_ffff >> (31 - tapA);
      for (i = WORD_W - 1; i >= 0; i = i - 1) begin
        fb = s[tapA-1] ^ s[tapB-1];
        w[i] = fb;
        s = {s[29:0], fb} & mask;
      end
      pnAdvance = {s, w};
    end
  endfunction

  assign pnStep = pnAdvance(lfsr_ff, patSel);

  always @* begin
    nxt_patWord  = patWord_ff;
    nxt_lfsr     = lfsr_ff;
    nxt_userSent = userSent_ff;
    if (patSel != lastSel_ff) begin
      // Restart so each new selection begins from a known seed
      nxt_patWord  = {WORD_W{1'b0}};
      nxt_lfsr     = 31'h7fff_ffff;
      nxt_userSent = 1'b0;
    end else if (stepEn) begin
      case (patSel)
        `SLTIC_PAT_CHECKER: begin // see R6
          nxt_patWord = (patWord_ff == {(WORD_W/2){2'b10}}) ?
                        {(WORD_W/2){2'b01}} : {(WORD_W/2){2'b10}};
        end
        `SLTIC_PAT_TOGGLE: begin // see R6
          nxt_patWord = ~patWord_ff;
        end
        `SLTIC_PAT_PN31, `SLTIC_PAT_PN23, `SLTIC_PAT_PN15,
        `SLTIC_PAT_PN9, `SLTIC_PAT_PN7: begin
          nxt_patWord = pnStep[WORD_W-1:0];
          nxt_lfsr    = pnStep[30+WORD_W:WORD_W];
        end
        `SLTIC_PAT_RAMP: begin
          nxt_patWord = patWord_ff + {{(WORD_W-1){1'b0}}, 1'b1};
        end
        `SLTIC_PAT_USER_REP: begin
          nxt_patWord = userWord;
        end
        `SLTIC_PAT_USER_ONE: begin
          nxt_patWord  = userSent_ff ? {WORD_W{1'b0}} : userWord;
          nxt_userSent = 1'b1;
        end
        default: begin // see R6
          nxt_patWord = {WORD_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      patWord_ff  <= {WORD_W{1'b0}};
      lfsr_ff     <= 31'h7fff_ffff;
      lastSel_ff  <= 4'h0;
      userSent_ff <= 1'b0;
    end else begin
      patWord_ff  <= nxt_patWord;
      lfsr_ff     <= nxt_lfsr;
      lastSel_ff  <= patSel;
      userSent_ff <= nxt_userSent;
    end
  end

endmodule

// *** hw/sltic_regs.vh ***
`ifndef SLTIC_REGS_VH
`define SLTIC_REGS_VH

// Register indices; byte address is four times the index
`define SLTIC_IDX_SYNC_CTRL   12'h572
`define SLTIC_IDX_CHK_TEST    12'h573
`define SLTIC_IDX_ALIGN_DLY   12'h574
`define SLTIC_IDX_LMFC_OFS    12'h578
`define SLTIC_IDX_CFG0        12'h600
`define SLTIC_IDX_CFG1        12'h601
`define SLTIC_IDX_CFG2        12'h602
`define SLTIC_IDX_CFG3        12'h603
`define SLTIC_IDX_USER_PAT    12'h604
`define SLTIC_IDX_STATUS      12'h605

// Reset values
`define SLTIC_RST_BYTE        8'h00
`define SLTIC_RST_WORD        32'h0000_0000

// Checksum and test select fields
`define SLTIC_CHK_MSB         7
`define SLTIC_CHK_LSB         6
`define SLTIC_INJ_MSB         5
`define SLTIC_INJ_LSB         4
`define SLTIC_PAT_MSB         3
`define SLTIC_PAT_LSB         0
`define SLTIC_CHK_TABLE       2'h0
`define SLTIC_CHK_FIELDS      2'h1
`define SLTIC_CHK_ZERO        2'h2
`define SLTIC_INJ_SAMPLE      2'h0
`define SLTIC_INJ_ENCODER     2'h1
`define SLTIC_INJ_SCRAMBLER   2'h2

// Alignment delay and sync control fields
`define SLTIC_DLY_MSB         7
`define SLTIC_DLY_LSB         4
`define SLTIC_SYNC_MSB        7
`define SLTIC_SYNC_LSB        6
`define SLTIC_SYNC_FORCE_CGS  2'h2
`define SLTIC_SYNC_FORCE_DATA 2'h3
`define SLTIC_OFS_MSB         4

// Test pattern codes
`define SLTIC_PAT_NORMAL      4'h0
`define SLTIC_PAT_CHECKER     4'h1
`define SLTIC_PAT_TOGGLE      4'h2
`define SLTIC_PAT_PN31        4'h3
`define SLTIC_PAT_PN23        4'h4
`define SLTIC_PAT_PN15        4'h5
`define SLTIC_PAT_PN9         4'h6
`define SLTIC_PAT_PN7         4'h7
`define SLTIC_PAT_RAMP        4'h8
`define SLTIC_PAT_USER_REP    4'he
`define SLTIC_PAT_USER_ONE    4'hf

// AXI responses
`define SLTIC_RESP_OKAY       2'h0
`define SLTIC_RESP_SLVERR     2'h2

`endif
